// ---- design/pwm_sync_defines.vh ----
// Purpose: register offsets, field positions and reset values of the PWM block
// Assumes: Avalon-MM word addressing, one 32-bit word per register
// Notes: byte address = 4 * word index
`ifndef PWM_SYNC_DEFINES_VH
`define PWM_SYNC_DEFINES_VH

`define ADDR_PERIOD        4'h0
`define ADDR_CHANGE1       4'h1
`define ADDR_CHANGE2       4'h2
`define ADDR_CHANGE3       4'h3
`define ADDR_PIN_DISABLE   4'h4
`define ADDR_CUTOFF_EN     4'h5
`define ADDR_STATUS        4'h6
`define ADDR_IRQ_EN        4'h7
`define ADDR_START         4'h8
`define ADDR_PRIORITY      4'h9
`define ADDR_MODE          4'ha
`define ADDR_CLEAR_SEL     4'hb
`define ADDR_COUNTER       4'hc
`define ADDR_MASK          4'hd

`define BIT_PIN_B0         1
`define BIT_PIN_D0         3
`define BIT_PIN_A1         4
`define BIT_PIN_B1         5
`define BIT_PIN_C1         6
`define BIT_PIN_D1         7
`define BIT_CUTOFF_EN      7
`define BIT_PERIOD_FLAG    0
`define BIT_PERIOD_IRQ_EN  0
`define BIT_RUN            0
`define BIT_REQ_PENDING    3
`define BIT_NORMAL_LVL     2
`define BIT_COUNTER_LVL    3

`define MODE_RESET_SYNC    2'h1
`define CLEAR_ON_PERIOD    3'h1
`define RST_PIN_DISABLE    8'hff
`define RST_PERIOD         16'hffff
`define RST_CHANGE         16'hffff

`endif

// ---- design/reset_sync_pwm_three_phase.v ----
// Purpose: reset-synchronous three-phase PWM channel with Avalon-MM registers
// Assumes: one 10 MHz clock, synchronous active-high reset, inputs synchronous
// Notes: every access takes one wait state; read data comes from flip-flops
//        clearing the period flag needs a read that saw it set, then a zero
//        write; a period match in the same cycle keeps the flag set
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pwm_sync_defines.vh"

module reset_sync_pwm_three_phase (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // External forced cutoff, high requests shutdown
    input  wire        cutoff_in,
    // PWM pins: value and output enable
    output reg  [5:0]  pwm_out,
    output reg  [5:0]  pwm_oe,
    // Interrupt
    output wire        irq
);

    // Software-visible registers, plus the internal flag_read_seen
    reg  [15:0] pwm_period_compare;
    reg  [15:0] first_change_point;
    reg  [15:0] second_change_point;
    reg  [15:0] third_change_point;
    reg  [7:0]  pin_output_disable;
    reg         cutoff_input_enable;
    reg         period_match_flag;
    reg         flag_read_seen;
    reg         period_match_irq_enable;
    reg         channel0_run_flag;
    reg  [2:0]  priority_level_field;
    reg  [1:0]  combination_mode;
    reg  [2:0]  counter_clear_select;
    reg         normal_phase_level_select;
    reg         counter_phase_level_select;
    reg         irq_mask;

    // Counter and phase state
    reg  [15:0] channel0_counter;
    reg  [2:0]  phase_active;

    // Bus handshake
    reg         ack;

    wire        access    = read | write;
    wire        wr        = write & ack;
    wire        rd        = read & ack;
    wire        pwm_mode  = (combination_mode == `MODE_RESET_SYNC);
    wire        period_hit = channel0_run_flag &&
                            (channel0_counter == pwm_period_compare);
    wire [15:0] change_point [0:2];
    wire        cut = cutoff_input_enable & cutoff_in;
    wire [5:0]  pin_bit_disable;
    wire        pending = period_match_flag & period_match_irq_enable;

    assign change_point[0] = first_change_point;
    assign change_point[1] = second_change_point;
    assign change_point[2] = third_change_point;

    // One wait cycle lets reads come from flip-flops
    assign waitrequest = access & ~ack;
    assign irq = pending & irq_mask & (priority_level_field != 3'h0);

    // Pin order: b0, d0, a1, c1, b1, d1 (normal, partner pairs)
    assign pin_bit_disable = {pin_output_disable[`BIT_PIN_D1],
                              pin_output_disable[`BIT_PIN_B1],
                              pin_output_disable[`BIT_PIN_C1],
                              pin_output_disable[`BIT_PIN_A1],
                              pin_output_disable[`BIT_PIN_D0],
                              pin_output_disable[`BIT_PIN_B0]};

    always @(posedge clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    // Register writes; byte lane 0 carries 8-bit registers
    always @(posedge clk) begin
        if (sys_rst) begin
            pwm_period_compare         <= `RST_PERIOD;
            first_change_point         <= `RST_CHANGE;
            second_change_point        <= `RST_CHANGE;
            third_change_point         <= `RST_CHANGE;
            pin_output_disable         <= `RST_PIN_DISABLE;
            cutoff_input_enable        <= 1'b0;
            period_match_irq_enable    <= 1'b0;
            channel0_run_flag          <= 1'b0;
            priority_level_field       <= 3'h0;
            combination_mode           <= 2'h0;
            counter_clear_select       <= 3'h0;
            normal_phase_level_select  <= 1'b0;
            counter_phase_level_select <= 1'b0;
            irq_mask                   <= 1'b0;
        end else if (wr) begin
            case (address)
                `ADDR_PERIOD: begin
                    if (byteenable[0]) begin
                        pwm_period_compare[7:0] <= writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        pwm_period_compare[15:8] <= writedata[15:8];
                    end
                end

                `ADDR_CHANGE1: begin
                    if (byteenable[0]) begin
                        first_change_point[7:0] <= writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        first_change_point[15:8] <= writedata[15:8];
                    end
                end

                `ADDR_CHANGE2: begin
                    if (byteenable[0]) begin
                        second_change_point[7:0] <= writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        second_change_point[15:8] <= writedata[15:8];
                    end
                end

                `ADDR_CHANGE3: begin
                    if (byteenable[0]) begin
                        third_change_point[7:0] <= writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        third_change_point[15:8] <= writedata[15:8];
                    end
                end

                `ADDR_PIN_DISABLE: begin
                    if (byteenable[0]) begin
                        pin_output_disable <= writedata[7:0];
                    end
                end

                `ADDR_CUTOFF_EN: begin
                    if (byteenable[0]) begin
                        cutoff_input_enable <= writedata[`BIT_CUTOFF_EN];
                    end
                end

                `ADDR_IRQ_EN: begin
                    if (byteenable[0]) begin
                        period_match_irq_enable <= writedata[`BIT_PERIOD_IRQ_EN];
                    end
                end

                `ADDR_START: begin
                    if (byteenable[0]) begin
                        channel0_run_flag <= writedata[`BIT_RUN];
                    end
                end

                `ADDR_PRIORITY: begin
                    if (byteenable[0]) begin
                        priority_level_field <= writedata[2:0];
                    end
                end

                `ADDR_MODE: begin
                    if (byteenable[0]) begin
                        combination_mode           <= writedata[1:0];
                        normal_phase_level_select  <= writedata[`BIT_NORMAL_LVL];
                        counter_phase_level_select <= writedata[`BIT_COUNTER_LVL];
                    end
                end

                `ADDR_CLEAR_SEL: begin
                    if (byteenable[0]) begin
                        counter_clear_select <= writedata[2:0];
                    end
                end

                `ADDR_MASK: begin
                    if (byteenable[0]) begin
                        irq_mask <= writedata[`BIT_PERIOD_FLAG];
                    end
                end

                // Status and counter words are written by their own processes
                default: begin
                end
            endcase
        end
    end

    // Flag clears only by a zero write after the set flag was read; a new
    // period match in the same cycle wins over the clear.
    always @(posedge clk) begin
        if (sys_rst) begin
            period_match_flag <= 1'b0;
            flag_read_seen    <= 1'b0;
        end else begin
            if (rd && address == `ADDR_STATUS && period_match_flag) begin
                flag_read_seen <= 1'b1;
            end else if (wr && address == `ADDR_STATUS && byteenable[0]) begin
                flag_read_seen <= 1'b0;
            end
            if (period_hit) begin
                period_match_flag <= 1'b1;
            end else if (wr && address == `ADDR_STATUS && byteenable[0] &&
                         !writedata[`BIT_PERIOD_FLAG] && flag_read_seen) begin
                period_match_flag <= 1'b0;
            end
        end
    end

    // Counter; direct writes allowed through the counter word
    // A write wins over counting so software can preset a start value
    always @(posedge clk) begin
        if (sys_rst) begin
            channel0_counter <= 16'h0000;
        end else if (wr && address == `ADDR_COUNTER) begin
            if (byteenable[0]) begin
                channel0_counter[7:0] <= writedata[7:0];
            end
            if (byteenable[1]) begin
                channel0_counter[15:8] <= writedata[15:8];
            end
        end else if (channel0_run_flag) begin
            if (period_hit && counter_clear_select == `CLEAR_ON_PERIOD) begin
                channel0_counter <= 16'h0000;
            end else begin
                channel0_counter <= channel0_counter + 16'h0001;
            end
        end
    end

    // Phase state: active from change match, inactive again at period match
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : phase
            always @(posedge clk) begin
                if (sys_rst || !pwm_mode) begin
                    phase_active[g] <= 1'b0;
                end else if (period_hit) begin
                    phase_active[g] <= 1'b0;
                end else if (channel0_run_flag &&
                             channel0_counter == change_point[g]) begin
                    phase_active[g] <= 1'b1;
                end
            end

            // Level select zero: inactive high, active low
            always @(posedge clk) begin
                if (sys_rst) begin
                    pwm_out[2*g]   <= 1'b0;
                    pwm_out[2*g+1] <= 1'b0;
                    pwm_oe[2*g]    <= 1'b0;
                    pwm_oe[2*g+1]  <= 1'b0;
                end else begin
                    pwm_out[2*g]   <= phase_active[g] ^ ~normal_phase_level_select;
                    pwm_out[2*g+1] <= ~phase_active[g] ^ ~counter_phase_level_select;
                    pwm_oe[2*g]    <= pwm_mode & ~pin_bit_disable[2*g] & ~cut;
                    pwm_oe[2*g+1]  <= pwm_mode & ~pin_bit_disable[2*g+1] & ~cut;
                end
            end
        end
    endgenerate

    // Read data registered at the end of the wait cycle, for reads and writes alike; unmapped reads zero
    always @(posedge clk) begin
        if (sys_rst) begin
            readdata <= 32'h00000000;
        end else if (access && !ack) begin
            case (address)
                `ADDR_PERIOD: begin
                    readdata <= {16'h0000, pwm_period_compare};
                end
                `ADDR_CHANGE1: begin
                    readdata <= {16'h0000, first_change_point};
                end
                `ADDR_CHANGE2: begin
                    readdata <= {16'h0000, second_change_point};
                end
                `ADDR_CHANGE3: begin
                    readdata <= {16'h0000, third_change_point};
                end
                `ADDR_PIN_DISABLE: begin
                    readdata <= {24'h000000, pin_output_disable};
                end
                `ADDR_CUTOFF_EN: begin
                    readdata <= {24'h000000, cutoff_input_enable, 7'h00};
                end
                `ADDR_STATUS: begin
                    readdata <= {31'h00000000, period_match_flag};
                end
                `ADDR_IRQ_EN: begin
                    readdata <= {31'h00000000, period_match_irq_enable};
                end
                `ADDR_START: begin
                    readdata <= {31'h00000000, channel0_run_flag};
                end
                `ADDR_PRIORITY: begin
                    readdata <= {28'h0000000, pending, priority_level_field};
                end
                `ADDR_MODE: begin
                    readdata <= {28'h0000000, counter_phase_level_select,
                                 normal_phase_level_select, combination_mode};
                end
                `ADDR_CLEAR_SEL: begin
                    readdata <= {29'h00000000, counter_clear_select};
                end
                `ADDR_COUNTER: begin
                    readdata <= {16'h0000, channel0_counter};
                end
                `ADDR_MASK: begin
                    readdata <= {31'h00000000, irq_mask};
                end
                default: begin
                    readdata <= 32'h00000000;
                end
            endcase
        end
    end

endmodule // reset_sync_pwm_three_phase

// ---- test/pwm_sync_chk.sv ----
// Purpose: port checks of the PWM block
// Assumes: one clock, synchronous reset
// Notes: pin pairs are compared only while both pins are driven
`timescale 1ns/1ps
module pwm_sync_chk (
    // Clock and bus
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Pins
    input wire logic        cutoff_in,
    input wire logic [5:0]  pwm_out,
    input wire logic [5:0]  pwm_oe,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_new_req;
        (read || write) && !$past(read || write);
    endsequence
    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    a_one_wait_state: assert property (s_new_req |-> s_one_wait)
        else $error("wait state count wrong");
    a_read_hold: assert property (!$past(read || write) |-> $stable(readdata))
        else $error("read data moved without a read");
    a_pair_one_inv: assert property (!$past(sys_rst) && &pwm_oe[1:0] |-> pwm_out[1] != pwm_out[0])
        else $error("first pair not inverse");
    a_pair_two_inv: assert property (!$past(sys_rst) && &pwm_oe[3:2] |-> pwm_out[3] != pwm_out[2])
        else $error("second pair not inverse");
    a_pair_three_inv: assert property (!$past(sys_rst) && &pwm_oe[5:4] |-> pwm_out[5] != pwm_out[4])
        else $error("third pair not inverse");
    a_reset_quiet: assert property ($past(sys_rst) |-> pwm_oe == 6'h00 && readdata == 32'h0 && !irq)
        else $error("outputs not quiet after reset");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(write))
        else $error("irq dropped without a write");
    // Enables move only after a register write unless the cutoff input was high one or two cycles before
    a_oe_cause: assert property (!$stable(pwm_oe) && !$past(cutoff_in) && !$past(cutoff_in, 2)
        |-> $past(write) || $past(write, 2))
        else $error("pin enable moved without a write");
endmodule // pwm_sync_chk
bind reset_sync_pwm_three_phase pwm_sync_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .cutoff_in(cutoff_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));

// ---- test/pwm_stage_model.sv ----
// Purpose: power stage seen from the PWM pins
// Assumes: pin levels sampled on clk
// Notes: gate lines have no pull, so an undriven pin toggles
`timescale 1ns/1ps
module pwm_stage_model (
    // Pins from the block
    input  wire logic        clk,
    input  wire logic [5:0]  pwm_out,
    input  wire logic [5:0]  pwm_oe,
    // Low width of each normal pin, cycle of the first
    output logic      [47:0] low_len,
    output logic      [15:0] cycle_len
);
    logic [5:0]  pin = 6'h00;
    logic        was_hi = 1'b0;
    logic [47:0] run = '0;
    logic [15:0] cyc = 16'h0000;
    always @(posedge clk) begin
        pin <= (pwm_out & pwm_oe) | (~pin & ~pwm_oe);
        was_hi <= pin[0];
        cyc <= (pin[0] && !was_hi) ? 16'h0001 : cyc + 16'h0001;
        if (pin[0] && !was_hi)
            cycle_len <= cyc;
        for (int k = 0; k < 3; k++) begin
            run[16*k +: 16] <= pin[2*k] ? 16'h0000 : run[16*k +: 16] + 16'h0001;
            if (pin[2*k] && run[16*k +: 16] != 16'h0000)
                low_len[16*k +: 16] <= run[16*k +: 16];
        end
    end
endmodule // pwm_stage_model

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the PWM block
// Assumes: 10 MHz clock, one Avalon master
// Notes: short random periods keep the run brief
`timescale 1ns/1ps
`include "pwm_sync_defines.vh"
module tb_top;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        cutoff_in = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] seed = 32'h362a0e52;
    logic [31:0] q;
    logic [31:0] readdata;
    logic [15:0] per;
    logic [15:0] cycle_len;
    logic [15:0] cp [3];
    logic [47:0] low_len;
    logic [5:0]  pwm_out, pwm_oe;
    logic        waitrequest, irq;
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          pin_bit [6] = '{`BIT_PIN_B0, `BIT_PIN_D0, `BIT_PIN_A1, `BIT_PIN_C1,
                                 `BIT_PIN_B1, `BIT_PIN_D1};
    reset_sync_pwm_three_phase u_dut (.clk(clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .cutoff_in(cutoff_in),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
    pwm_stage_model u_stage (.clk(clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .low_len(low_len), .cycle_len(cycle_len));
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] low_width(input logic [15:0] p, input logic [15:0] c);
        return p - c;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Request is held until waitrequest is seen low; only the global timeout ends a wait
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] exp, input string nm);
        bus(a, 1'b0, 32'h0);
        chk(nm, exp, q);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rc(`ADDR_PERIOD, {16'h0, `RST_PERIOD}, "period");
        rc(`ADDR_PIN_DISABLE, {24'h0, `RST_PIN_DISABLE}, "pin disable");
        bus(4'he, 1'b1, 32'hffffffff);
        rc(4'he, 32'h0, "unmapped");
        bus(`ADDR_MODE, 1'b1, {30'h0, `MODE_RESET_SYNC});
        bus(`ADDR_CLEAR_SEL, 1'b1, {29'h0, `CLEAR_ON_PERIOD});
        bus(`ADDR_PIN_DISABLE, 1'b1, 32'h1);
        for (int r = 0; r < 3; r++) begin
            seed = xs(seed);
            per = 16'd12 + {12'h0, seed[3:0]};
            for (int k = 0; k < 3; k++) begin
                seed = xs(seed);
                cp[k] = 16'd1 + seed[15:0] % (per - 16'd1);
            end
            if (r == 0) begin
                cp[0] = 16'd1;
                cp[2] = per - 16'd1;
            end
            bus(`ADDR_START, 1'b1, 32'h0);
            bus(`ADDR_PERIOD, 1'b1, {16'h0, per});
            for (int k = 0; k < 3; k++) begin
                bus(`ADDR_CHANGE1 + 4'(k), 1'b1, {16'h0, cp[k]});
                rc(`ADDR_CHANGE1 + 4'(k), {16'h0, cp[k]}, "change point");
            end
            bus(`ADDR_COUNTER, 1'b1, 32'h0);
            bus(`ADDR_START, 1'b1, 32'h1);
            repeat (4 * per + 8) @(posedge clk);
            chk("oe", 32'h3f, {26'h0, pwm_oe});
            chk("cycle", {16'h0, per + 16'd1}, {16'h0, cycle_len});
            for (int k = 0; k < 3; k++)
                chk("low", {16'h0, low_width(per, cp[k])}, {16'h0, low_len[16*k +: 16]});
        end
        for (int i = 0; i < 6; i++) begin
            bus(`ADDR_PIN_DISABLE, 1'b1, 32'h1 | (32'h1 << pin_bit[i]));
            rc(`ADDR_PIN_DISABLE, 32'h1 | (32'h1 << pin_bit[i]), "pin disable");
            chk("oe off", {26'h0, 6'h3f & ~(6'h1 << i)}, {26'h0, pwm_oe});
        end
        bus(`ADDR_PIN_DISABLE, 1'b1, 32'h1);
        cutoff_in <= 1'b1;
        bus(`ADDR_CUTOFF_EN, 1'b1, 32'h0);
        rc(`ADDR_CUTOFF_EN, 32'h0, "cutoff enable");
        chk("oe cutoff", 32'h3f, {26'h0, pwm_oe});
        bus(`ADDR_CUTOFF_EN, 1'b1, 32'h80);
        rc(`ADDR_CUTOFF_EN, 32'h80, "cutoff enable set");
        chk("oe cut", 32'h0, {26'h0, pwm_oe});
        bus(`ADDR_CUTOFF_EN, 1'b1, 32'h0);
        cutoff_in <= 1'b0;
        bus(`ADDR_MODE, 1'b1, 32'h0);
        rc(`ADDR_MODE, 32'h0, "mode");
        chk("oe mode", 32'h0, {26'h0, pwm_oe});
        bus(`ADDR_MODE, 1'b1, {30'h0, `MODE_RESET_SYNC});
        bus(`ADDR_IRQ_EN, 1'b1, 32'h1);
        bus(`ADDR_MASK, 1'b1, 32'h1);
        bus(`ADDR_PRIORITY, 1'b1, 32'h1);
        repeat (2 * per + 4) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rc(`ADDR_PRIORITY, 32'h9, "priority");
        bus(`ADDR_START, 1'b1, 32'h0);
        bus(`ADDR_COUNTER, 1'b1, 32'h0);
        bus(`ADDR_STATUS, 1'b1, 32'h0);
        rc(`ADDR_STATUS, 32'h1, "flag unread");
        bus(`ADDR_STATUS, 1'b1, 32'h0);
        rc(`ADDR_STATUS, 32'h0, "flag");
        chk("irq clear", 32'h0, {31'h0, irq});
        repeat (5) @(posedge clk);
        rc(`ADDR_COUNTER, 32'h0, "held count");
        conclude();
    end
endmodule // tb_top
